// ==== shared/dptrg_pkg.sv ====
// Package with register map, field layouts and constants for the drum pattern trigger
// Operation
// - Pattern zero disables, others select presets
// - Add signed transpose within plus/minus 24
// - Immediate mode: on starts, off stops
// - Key mode: on arms, note-on starts
// - Immediate mode saves control as off
// - Unlatched: note-off of trigger key stops
// - Latched: only control off stops
// - Trigger key must lie in range
// - Trigger velocity must lie in range
// - Input channel fixed or follow-track
// - Song mode uses per-song input channel; here the song bit is unused and CHAN applies
// - Output channel fixed or follow-track
// - External send only for outward statuses
// - Sync defers start to beat
// - Sync off starts at once
// - Sequencer notes never trigger
// - Generated notes passed to recorder
// - Local off: keyboard ignored, MIDI triggers
// - Song playing aligns to next measure
package dptrg_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DPTRG_CTRL_ADDR = 8'h00;    // Mode and enable bits
    localparam logic [7:0] DPTRG_PATT_ADDR = 8'h04;    // Pattern and transpose
    localparam logic [7:0] DPTRG_ZONE_ADDR = 8'h08;    // Key and velocity zone
    localparam logic [7:0] DPTRG_CHAN_ADDR = 8'h0c;    // Channels
    localparam logic [7:0] DPTRG_STAT_ADDR = 8'h10;    // Player status, read only
    localparam logic [7:0] DPTRG_SAVE_ADDR = 8'h14;    // Saved control image, read only
    localparam logic [7:0] DPTRG_TSTAT_ADDR = 8'h18;   // Track status codes, two bits each

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int DPTRG_CTRL_ON_BIT = 0;      // Player control switch
    localparam int DPTRG_CTRL_KEYMODE_BIT = 1; // Key-trigger mode
    localparam int DPTRG_CTRL_SYNC_BIT = 2;    // Trigger sync
    localparam int DPTRG_CTRL_LATCH_BIT = 3;   // Latch
    localparam int DPTRG_CTRL_LOCAL_BIT = 4;   // Local keyboard coupled
    localparam int DPTRG_CTRL_SONG_BIT = 5;    // Song mode context

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [5:0] DPTRG_CTRL_RST = 6'h10;     // Local coupled, all else off
    localparam logic [9:0] DPTRG_PATT_RST = 10'h000;   // No pattern
    localparam logic [5:0] DPTRG_SHIFT_RST = 6'h00;    // No transpose
    localparam logic [6:0] DPTRG_KEY_BOT_RST = 7'h00;  // Note 0
    localparam logic [6:0] DPTRG_KEY_TOP_RST = 7'h7f;  // Note 127
    localparam logic [6:0] DPTRG_VEL_BOT_RST = 7'h01;  // Velocity 1
    localparam logic [6:0] DPTRG_VEL_TOP_RST = 7'h7f;  // Velocity 127
    localparam logic [4:0] DPTRG_CHAN_RST = 5'h10;     // Follow-track
    localparam logic [31:0] DPTRG_TSTAT_RST = 32'h0000_0000; // All internal

    // ------------------------------------------------------------
    // Ranges and encodings
    // ------------------------------------------------------------
    localparam logic [9:0] DPTRG_PATT_TOP = 10'h304;   // Index 772
    localparam logic signed [5:0] DPTRG_SHIFT_MAX = 6'sh18;  // +24
    localparam logic signed [5:0] DPTRG_SHIFT_MIN = -6'sh18; // -24
    localparam logic [4:0] DPTRG_CHAN_FOLLOW = 5'h10;  // Channel code for follow-track
    localparam logic [1:0] DPTRG_ST_INT = 2'h0;        // Internal only
    localparam logic [1:0] DPTRG_ST_BOTH = 2'h1;       // status_internal_and_outside
    localparam logic [1:0] DPTRG_ST_EXT = 2'h2;        // External
    localparam logic [1:0] DPTRG_ST_EXT2 = 2'h3;       // status_outside_second

    // Note source codes
    localparam logic [1:0] DPTRG_SRC_KEYS = 2'h0;      // Local keyboard
    localparam logic [1:0] DPTRG_SRC_MIDI = 2'h1;      // MIDI input
    localparam logic [1:0] DPTRG_SRC_SEQ = 2'h2;       // Internal song sequencer

    // Player states
    typedef enum logic [1:0] {
        DPTRG_IDLE,
        DPTRG_AWAIT_KEY_TRIGGER,
        DPTRG_PENDING,
        DPTRG_RUNNING
    } dptrg_state_t;

endpackage : dptrg_pkg

// ==== core/dptrg_core.sv ====
// Drum pattern trigger and routing controller with APB register access
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dptrg_core #(
    parameter int NTRK = 16                    // Number of tracks
) (
    input wire logic clk,                      // 25 MHz system clock
    input wire logic rst_n,                    // Asynchronous reset, active low
    input wire logic clk_en,                   // Freezes all state while low

    // APB slave
    input wire logic psel,                     // Slave select
    input wire logic penable,                  // Access phase
    input wire logic pwrite,                   // Write direction
    input wire logic [7:0] paddr,              // Byte address
    input wire logic [31:0] pwdata,            // Write data
    output logic [31:0] prdata,                // Read data
    output logic pready,                       // Ready at once for writes, one cycle into a read
    output logic pslverr,                      // Unmapped address error

    // Incoming notes
    input wire logic in_valid,                 // Note event strobe
    input wire logic [1:0] in_src,             // Source of the note
    input wire logic in_on,                    // Note-on when high, off when low
    input wire logic [3:0] in_chan,            // Channel, zero based
    input wire logic [6:0] in_note,            // Note number
    input wire logic [6:0] in_vel,             // Velocity

    // Song and tempo context
    input wire logic [3:0] sel_track_chan,     // Channel of the selected track
    input wire logic beat_tick,                // Beat pulse from tempo source
    input wire logic measure_tick,             // Measure start pulse
    input wire logic song_playing,             // Song playback running
    input wire logic recording,                // Realtime recording active

    // Pattern note stream from player storage
    input wire logic pat_valid,                // Pattern note strobe
    input wire logic pat_on,                   // Pattern note-on
    input wire logic [6:0] pat_note,           // Pattern stored note
    input wire logic [6:0] pat_vel,            // Pattern velocity

    // Outputs
    output logic running,                      // Pattern playing
    output logic [9:0] pattern_sel,            // Active preset, zero when none
    output logic out_valid,                    // Emitted note strobe
    output logic out_on,                       // Emitted note-on
    output logic [3:0] out_chan,               // Emitted channel
    output logic [6:0] out_note,               // Transposed note
    output logic [6:0] out_vel,                // Emitted velocity
    output logic out_ext,                      // Send to external MIDI output
    output logic rec_valid                     // Event passed to recorder
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] ctrl;                      // Control bits
        logic [9:0] patt;                      // Pattern selection
        logic [5:0] shift;                     // Signed transpose
        logic [6:0] key_bot;                   // Key zone bottom
        logic [6:0] key_top;                   // Key zone top
        logic [6:0] vel_bot;                   // Velocity zone bottom
        logic [6:0] vel_top;                   // Velocity zone top
        logic [4:0] in_ch;                     // Input channel code
        logic [4:0] out_ch;                    // Output channel code
        logic [31:0] tstat;                    // Per-track status

        logic [6:0] trig_note;                 // Key that started the pattern
        dptrg_pkg::dptrg_state_t st;           // Player state
        logic [31:0] rdata;                    // Read data register
        logic rrdy; // Read data ready

        logic ovalid;                          // Output strobe
        logic oon;
        logic [3:0] och;
        logic [6:0] onote;
        logic [6:0] ovel;
        logic oext;
        logic orec;
    } dptrg_regs_t;

    dptrg_regs_t s_q;                          // Registered state
    dptrg_regs_t s_d;                          // Next state

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Resolve a channel code; follow-track reads the live selected track
    function automatic logic [3:0] dptrg_eff_chan(input logic [4:0] code,
                                                  input logic [3:0] trk);
        dptrg_eff_chan = (code == dptrg_pkg::DPTRG_CHAN_FOLLOW) ? trk : code[3:0];
    endfunction : dptrg_eff_chan

    // Clamp a written transpose into its legal span
    function automatic logic [5:0] dptrg_clamp_shift(input logic [5:0] v);
        logic signed [5:0] sv;
        sv = $signed(v);
        if (sv > dptrg_pkg::DPTRG_SHIFT_MAX) begin
            dptrg_clamp_shift = dptrg_pkg::DPTRG_SHIFT_MAX;
        end else if (sv < dptrg_pkg::DPTRG_SHIFT_MIN) begin
            dptrg_clamp_shift = dptrg_pkg::DPTRG_SHIFT_MIN;
        end else begin
            dptrg_clamp_shift = v;
        end
    endfunction : dptrg_clamp_shift

    // Velocity limits are 1..127; zero is lifted to one
    function automatic logic [6:0] dptrg_vel_lim(input logic [6:0] v);
        dptrg_vel_lim = (v == 7'h00) ? 7'h01 : v;
    endfunction : dptrg_vel_lim

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    logic wr_en;                               // APB write in access phase
    logic rd_en;                               // APB read in access phase
    logic addr_ok;                             // Address is mapped

    logic ctrl_on;                             // Player control after write
    logic ctrl_rise;                           // Control switched on
    logic ctrl_fall;                           // Control switched off

    logic src_ok;                              // Source may trigger
    logic chan_ok;                             // Channel matches
    logic zone_ok;                             // Key and velocity in zone
    logic trig_on;                             // Qualifying note-on
    logic trig_off;                            // Matching note-off of trigger key
    logic align;                               // Synced start point

    logic [3:0] in_eff;                        // Effective input channel
    logic [3:0] out_eff;                       // Effective output channel
    logic [1:0] trk_st;                        // Status of track on output channel
    logic [8:0] sum;                           // Transposed note, signed wide

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    assign addr_ok = (paddr == dptrg_pkg::DPTRG_CTRL_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_PATT_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_ZONE_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_CHAN_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_STAT_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_SAVE_ADDR) ||
                     (paddr == dptrg_pkg::DPTRG_TSTAT_ADDR);

    // Control transitions come from software writes to the control word
    assign ctrl_on = (wr_en && paddr == dptrg_pkg::DPTRG_CTRL_ADDR) ?
                     pwdata[dptrg_pkg::DPTRG_CTRL_ON_BIT] :
                     s_q.ctrl[dptrg_pkg::DPTRG_CTRL_ON_BIT];
    assign ctrl_rise = ctrl_on && !s_q.ctrl[dptrg_pkg::DPTRG_CTRL_ON_BIT];
    assign ctrl_fall = !ctrl_on && s_q.ctrl[dptrg_pkg::DPTRG_CTRL_ON_BIT];

    // Follow-track resolved every cycle, so a track change applies at once
    assign in_eff = dptrg_eff_chan(s_q.in_ch, sel_track_chan);
    assign out_eff = dptrg_eff_chan(s_q.out_ch, sel_track_chan);

    // Sequencer notes never qualify; keyboard only while local is coupled
    assign src_ok = (in_src == dptrg_pkg::DPTRG_SRC_MIDI) ||
                    (in_src == dptrg_pkg::DPTRG_SRC_KEYS &&
                     s_q.ctrl[dptrg_pkg::DPTRG_CTRL_LOCAL_BIT]);
    assign chan_ok = (in_chan == in_eff);
    assign zone_ok = (in_note >= s_q.key_bot) && (in_note <= s_q.key_top) &&
                     (in_vel >= s_q.vel_bot) && (in_vel <= s_q.vel_top);
    assign trig_on = in_valid && in_on && src_ok && chan_ok && zone_ok;
    assign trig_off = in_valid && !in_on && src_ok && chan_ok &&
                      (in_note == s_q.trig_note);

    // Song playing waits for a measure, otherwise the next beat
    assign align = song_playing ? measure_tick : beat_tick;

    // Status lookup for the track on the output channel
    assign trk_st = s_q.tstat[{out_eff, 1'b0} +: 2];
    assign sum = {2'b00, pat_note} + {{3{s_q.shift[5]}}, s_q.shift};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ovalid = 1'b0;
        s_d.orec = 1'b0;

        // Register writes
        if (wr_en) begin
            unique case (paddr)
                dptrg_pkg::DPTRG_CTRL_ADDR: begin
                    s_d.ctrl = pwdata[5:0];
                end
                dptrg_pkg::DPTRG_PATT_ADDR: begin
                    // Out-of-range selections fall back to no pattern
                    s_d.patt = (pwdata[9:0] > dptrg_pkg::DPTRG_PATT_TOP) ?
                               dptrg_pkg::DPTRG_PATT_RST : pwdata[9:0];
                    s_d.shift = dptrg_clamp_shift(pwdata[21:16]);
                end
                dptrg_pkg::DPTRG_ZONE_ADDR: begin
                    s_d.key_bot = pwdata[6:0];
                    s_d.key_top = pwdata[14:8];
                    s_d.vel_bot = dptrg_vel_lim(pwdata[22:16]);
                    s_d.vel_top = dptrg_vel_lim(pwdata[30:24]);
                end
                dptrg_pkg::DPTRG_CHAN_ADDR: begin
                    s_d.in_ch = pwdata[4:0];
                    s_d.out_ch = pwdata[12:8];
                end
                dptrg_pkg::DPTRG_TSTAT_ADDR: begin
                    s_d.tstat = pwdata;
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end

        // Player sequencing
        unique case (s_q.st)
            dptrg_pkg::DPTRG_IDLE: begin
                if (ctrl_rise && s_q.patt != dptrg_pkg::DPTRG_PATT_RST) begin
                    // Mode taken from this write
                    if (s_d.ctrl[dptrg_pkg::DPTRG_CTRL_KEYMODE_BIT]) begin
                        s_d.st = dptrg_pkg::DPTRG_AWAIT_KEY_TRIGGER;
                    end else if (s_d.ctrl[dptrg_pkg::DPTRG_CTRL_SYNC_BIT]) begin
                        s_d.st = dptrg_pkg::DPTRG_PENDING;
                    end else begin
                        s_d.st = dptrg_pkg::DPTRG_RUNNING;
                    end
                end
            end

            dptrg_pkg::DPTRG_AWAIT_KEY_TRIGGER: begin
                if (ctrl_fall) begin
                    s_d.st = dptrg_pkg::DPTRG_IDLE;
                end else if (trig_on) begin
                    s_d.trig_note = in_note;
                    s_d.st = s_q.ctrl[dptrg_pkg::DPTRG_CTRL_SYNC_BIT] ?
                             dptrg_pkg::DPTRG_PENDING :
                             dptrg_pkg::DPTRG_RUNNING;
                end
            end

            dptrg_pkg::DPTRG_PENDING: begin
                if (ctrl_fall) begin
                    s_d.st = dptrg_pkg::DPTRG_IDLE;
                end else if (s_q.ctrl[dptrg_pkg::DPTRG_CTRL_KEYMODE_BIT] &&
                             !s_q.ctrl[dptrg_pkg::DPTRG_CTRL_LATCH_BIT] && trig_off) begin
                    // Key released before the beat: back to armed
                    s_d.st = dptrg_pkg::DPTRG_AWAIT_KEY_TRIGGER;
                end else if (align) begin
                    s_d.st = dptrg_pkg::DPTRG_RUNNING;
                end
            end

            dptrg_pkg::DPTRG_RUNNING: begin
                if (ctrl_fall) begin
                    s_d.st = dptrg_pkg::DPTRG_IDLE;
                end else if (s_q.ctrl[dptrg_pkg::DPTRG_CTRL_KEYMODE_BIT] &&
                             !s_q.ctrl[dptrg_pkg::DPTRG_CTRL_LATCH_BIT] && trig_off) begin
                    // Unlatched key mode rearms on release
                    s_d.st = dptrg_pkg::DPTRG_AWAIT_KEY_TRIGGER;
                end
            end
        endcase

        // Emit pattern notes while running
        if (s_q.st == dptrg_pkg::DPTRG_RUNNING && pat_valid) begin
            s_d.ovalid = 1'b1;
            s_d.oon = pat_on;
            s_d.och = out_eff;
            // Notes pushed outside 0..127 are pinned to the edge
            s_d.onote = sum[8] ? 7'h00 : (sum[7] ? 7'h7f : sum[6:0]);
            s_d.ovel = pat_vel;
            s_d.oext = (trk_st != dptrg_pkg::DPTRG_ST_INT);
            s_d.orec = recording;
        end

        // Read data
        s_d.rdata = 32'h0000_0000;
        // Ready one cycle into a read
        s_d.rrdy = rd_en && !s_q.rrdy;
        if (rd_en) begin
            unique case (paddr)
                dptrg_pkg::DPTRG_CTRL_ADDR: s_d.rdata = {26'h0, s_q.ctrl};
                dptrg_pkg::DPTRG_PATT_ADDR: s_d.rdata = {10'h0, s_q.shift, 6'h0, s_q.patt};
                dptrg_pkg::DPTRG_ZONE_ADDR: begin
                    s_d.rdata = {1'b0, s_q.vel_top, 1'b0, s_q.vel_bot,
                                 1'b0, s_q.key_top, 1'b0, s_q.key_bot};
                end
                dptrg_pkg::DPTRG_CHAN_ADDR: s_d.rdata = {19'h0, s_q.out_ch, 3'h0, s_q.in_ch};
                dptrg_pkg::DPTRG_STAT_ADDR: s_d.rdata = {23'h0, s_q.trig_note, s_q.st};
                dptrg_pkg::DPTRG_SAVE_ADDR: begin
                    // Immediate mode always saves the switch as off
                    s_d.rdata = {26'h0, s_q.ctrl[5:1],
                                 s_q.ctrl[dptrg_pkg::DPTRG_CTRL_ON_BIT] &&
                                 s_q.ctrl[dptrg_pkg::DPTRG_CTRL_KEYMODE_BIT]};
                end
                dptrg_pkg::DPTRG_TSTAT_ADDR: s_d.rdata = s_q.tstat;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{ctrl: dptrg_pkg::DPTRG_CTRL_RST, patt: dptrg_pkg::DPTRG_PATT_RST,
                     shift: dptrg_pkg::DPTRG_SHIFT_RST,
                     key_bot: dptrg_pkg::DPTRG_KEY_BOT_RST,
                     key_top: dptrg_pkg::DPTRG_KEY_TOP_RST,
                     vel_bot: dptrg_pkg::DPTRG_VEL_BOT_RST,
                     vel_top: dptrg_pkg::DPTRG_VEL_TOP_RST,
                     in_ch: dptrg_pkg::DPTRG_CHAN_RST, out_ch: dptrg_pkg::DPTRG_CHAN_RST,
                     tstat: dptrg_pkg::DPTRG_TSTAT_RST, trig_note: 7'h00,
                     st: dptrg_pkg::DPTRG_IDLE, rdata: 32'h0000_0000,
                     ovalid: 1'b0, oon: 1'b0, och: 4'h0, onote: 7'h00,
                     ovel: 7'h00, oext: 1'b0, orec: 1'b0, rrdy: 1'b0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_q.rdata;
    // Read data is registered, so a read access takes two access cycles
    assign pready = pwrite || s_q.rrdy;
    assign pslverr = psel && penable && pready && !addr_ok;

    assign running = (s_q.st == dptrg_pkg::DPTRG_RUNNING);
    assign pattern_sel = running ? s_q.patt : dptrg_pkg::DPTRG_PATT_RST;

    assign out_valid = s_q.ovalid;
    assign out_on = s_q.oon;
    assign out_chan = s_q.och;
    assign out_note = s_q.onote;
    assign out_vel = s_q.ovel;
    assign out_ext = s_q.oext && s_q.ovalid;
    assign rec_valid = s_q.orec && s_q.ovalid;

endmodule : dptrg_core

`default_nettype wire

// ==== testbench/dptrg_checker.sv ====
// Port relation checker of the drum pattern trigger
`timescale 1ns/1ps
`default_nettype none
module dptrg_checker (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic in_valid, // Note strobe
    input wire logic [1:0] in_src, // Note source
    input wire logic beat_tick, // Beat
    input wire logic measure_tick, // Measure
    input wire logic pat_valid, // Pattern note
    input wire logic recording, // Recording
    input wire logic running, // Playing
    input wire logic [9:0] pattern_sel, // Preset
    input wire logic out_valid, // Out strobe
    input wire logic out_ext, // External send
    input wire logic rec_valid // Recorder strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A sequencer note alone never starts
    sequence s_seq_note;
        in_valid && in_src == dptrg_pkg::DPTRG_SRC_SEQ && !psel && !beat_tick && !measure_tick;
    endsequence
    a_ready_access: assert property (psel && penable |-> ##[0:1] pready) else $error("pready low");
    a_idle_no_sel: assert property (!running |-> pattern_sel == 10'h000) else $error("sel");
    a_run_has_sel: assert property (running |-> pattern_sel != 10'h000) else $error("run");
    a_start_cause: assert property ($rose(running) |-> $past(in_valid || psel || beat_tick || measure_tick)) else $error("cause");
    a_seq_ignored: assert property (!running ##0 s_seq_note |=> !running) else $error("seq");
    a_out_from_pat: assert property (out_valid |-> $past(pat_valid)) else $error("out");
    a_ext_with_out: assert property (out_ext |-> out_valid) else $error("ext");
    a_rec_follows: assert property (out_valid |-> rec_valid == $past(recording)) else $error("rec");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("slverr");
endmodule : dptrg_checker
bind dptrg_core dptrg_checker dptrg_checker_inst (.*);
`default_nettype wire

// ==== testbench/dptrg_keys.sv ====
// Keyboard and MIDI input model issuing single note events
`timescale 1ns/1ps
`default_nettype none
module dptrg_keys (
    input wire logic clk, // Clock
    input wire logic req, // One event per high cycle
    input wire logic [20:0] ev, // Source, on, channel, note, velocity
    output logic in_valid, // Note strobe
    output logic [20:0] bus // Event fields
);
    // Fields flip outside events so a stale value never looks like a note
    always_ff @(posedge clk) begin
        in_valid <= req;
        bus <= req ? ev : ~bus;
    end
endmodule : dptrg_keys
`default_nettype wire

// ==== testbench/dptrg_core_tb.sv ====
// Self-checking bench of the drum pattern trigger
`timescale 1ns/1ps
`default_nettype none
module dptrg_core_tb;
    typedef struct packed {logic [1:0] s; logic [3:0] c; logic [6:0] n; logic [6:0] v; logic r;} dptrg_row_t;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, req = 1'h0;
    logic beat_tick = 1'h0, pat_valid = 1'h0, recording = 1'h1, err, pready, pslverr, in_valid;
    logic running, out_valid, out_on, out_ext, rec_valid;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [20:0] ev = 21'h0, bus;
    logic [9:0] pattern_sel;
    logic [3:0] out_chan;
    logic [6:0] pat_note = 7'h00, out_note, out_vel;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    // Zone is keys 36..60, velocity 10..100; input follows track channel 2
    dptrg_row_t rows[7] = '{'{2'h0, 4'h2, 7'h28, 7'h32, 1'h1}, '{2'h0, 4'h2, 7'h23, 7'h32, 1'h0},
        '{2'h0, 4'h2, 7'h3d, 7'h32, 1'h0}, '{2'h0, 4'h2, 7'h28, 7'h09, 1'h0},
        '{2'h1, 4'h2, 7'h3c, 7'h64, 1'h1}, '{2'h2, 4'h2, 7'h28, 7'h32, 1'h0},
        '{2'h1, 4'h5, 7'h28, 7'h32, 1'h0}};
    dptrg_keys dptrg_keys_inst (.clk(clk), .req(req), .ev(ev), .in_valid(in_valid), .bus(bus));
    dptrg_core dptrg_core_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_src(bus[20:19]),
        .in_on(bus[18]), .in_chan(bus[17:14]), .in_note(bus[13:7]), .in_vel(bus[6:0]),
        .sel_track_chan(4'h2), .beat_tick(beat_tick), .measure_tick(1'h0), .song_playing(1'h0),
        .recording(recording), .pat_valid(pat_valid), .pat_on(pat_valid), .pat_note(pat_note),
        .pat_vel(pat_note), .running(running), .pattern_sel(pattern_sel), .out_valid(out_valid),
        .out_on(out_on), .out_chan(out_chan), .out_note(out_note), .out_vel(out_vel),
        .out_ext(out_ext), .rec_valid(rec_valid));
    initial forever #20 clk = ~clk;
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // APB master: setup, access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    // Level checks wait two edges, so the exact start latency never matters
    task automatic run_is(input string n, input logic e);
        repeat (2) @(posedge clk);
        #1 chk(n, e, running);
    endtask : run_is
    task automatic note(input dptrg_row_t r, input logic on);
        @(posedge clk);
        ev <= {r.s, on, r.c, r.n, r.v};
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        repeat (2) @(posedge clk);
    endtask : note
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        #1 chk("idle", 32'h0, {running, pattern_sel});
        apb(1'h1, dptrg_pkg::DPTRG_ZONE_ADDR, 32'h640a3c24);
        apb(1'h1, dptrg_pkg::DPTRG_CHAN_ADDR, 32'h00000910);
        apb(1'h1, dptrg_pkg::DPTRG_TSTAT_ADDR, 32'h00080000);
        apb(1'h1, dptrg_pkg::DPTRG_PATT_ADDR, 32'h00280005);
        foreach (rows[i]) begin
            apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h13);
            note(rows[i], 1'h1);
            run_is("key start", rows[i].r);
            note(rows[i], 1'h0);
            run_is("key release", 1'h0);
            apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h10);
        end
        apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h1b);
        note(rows[0], 1'h1);
        note(rows[0], 1'h0);
        run_is("latched", 1'h1);
        apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h10);
        run_is("latch off", 1'h0);
        apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h11);
        run_is("immediate", 1'h1);
        chk("sel", 32'h5, pattern_sel);
        apb(1'h0, dptrg_pkg::DPTRG_SAVE_ADDR, 32'h0);
        chk("save on", 32'h10, rd);
        @(posedge clk);
        {pat_valid, pat_note} <= 8'ha8;
        @(posedge clk);
        pat_valid <= 1'h0;
        #1 chk("out", 32'h0000_3c90, {out_valid, out_ext, rec_valid, out_chan, out_note});
        apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h10);
        run_is("stop", 1'h0);
        apb(1'h0, 8'h3c, 32'h0);
        chk("slverr", 32'h1, err);
        apb(1'h1, dptrg_pkg::DPTRG_CTRL_ADDR, 32'h15);
        run_is("sync wait", 1'h0);
        @(posedge clk);
        beat_tick <= 1'h1;
        @(posedge clk);
        beat_tick <= 1'h0;
        run_is("sync beat", 1'h1);
        conclude();
    end
endmodule : dptrg_core_tb
`default_nettype wire
